// ---- uet_pkg.sv ----
// constants and types for the transmit/receive endpoint control block
package uet_pkg;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [5:0] TXD_ADDR = 6'h29;
	localparam logic [5:0] TXS_ADDR = 6'h2a;
	localparam logic [5:0] TXC_ADDR = 6'h2b;
	localparam logic [5:0] RXS_ADDR = 6'h2e;

	////////////////////////////////////////////////////////////////////////
	// transmit command fields
	localparam int TX_EN_BIT  = 0;
	localparam int LAST_BIT   = 1;
	localparam int TOGGLE_BIT = 2;
	localparam int FLUSH_BIT  = 3;
	localparam int REFILL_BIT = 4;
	localparam int WLIM_LSB   = 5;
	localparam int OVR_BIT    = 7;
	localparam logic [7:0] TXC_RESET = 8'h00;

	// transmit status fields
	localparam int URUN_BIT = 7;
	localparam int ACK_BIT  = 6;
	localparam int DONE_BIT = 5;
	localparam logic [4:0] FREE_MAX = 5'h1f;

	// receive status fields
	localparam int RX_ERR_BIT = 7;
	localparam int SETUP_BIT  = 6;
	localparam int RPID_BIT   = 5;
	localparam int RLAST_BIT  = 4;
	localparam logic [3:0] RECEIVE_BYTE_COUNT_MAX = 4'hf;
	localparam logic [7:0] RXS_RESET  = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// warning limit codes and thresholds
	localparam logic [1:0] WL_OFF = 2'h0;
	localparam logic [1:0] WL_4   = 2'h1;
	localparam logic [1:0] WL_8   = 2'h2;
	localparam logic [4:0] TH_4   = 5'h04;
	localparam logic [4:0] TH_8   = 5'h08;
	localparam logic [4:0] TH_16  = 5'h10;

	// transmit buffer shape
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 4;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_EOP  = 2'b10,
		ST_HS   = 2'b11
	} uet_tx_state_t;

endpackage

// ---- uet_fifo.sv ----
// transmit byte buffer with saved read pointer for packet refill
module uet_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     in_valid_i,
	input  wire logic [WIDTH-1:0]         in_data_i,
	output logic                          in_ready_o,
	output logic                          out_valid_o,
	output logic [WIDTH-1:0]              out_data_o,
	input  wire logic                     out_ready_i,
	input  wire logic                     flush_i,
	input  wire logic                     save_i,
	input  wire logic                     restore_i,
	output logic [$clog2(DEPTH):0]        count_o
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_r;
	logic [AW:0]      rd_r;
	logic [AW:0]      sv_r;
	logic [AW:0]      held;
	logic             push;
	logic             pop;

	// bytes behind the saved pointer stay protected for a resend
	assign held        = wr_r - sv_r;
	assign count_o     = wr_r - rd_r;
	assign in_ready_o  = held != FULL_CNT;
	assign out_valid_o = count_o != '0;
	assign out_data_o  = mem[rd_r[AW-1:0]];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || flush_i)
		begin
			wr_r <= '0;
			rd_r <= '0;
			sv_r <= '0;
		end
		else
		begin
			if (push)
				wr_r <= wr_r + 1'b1;
			if (restore_i)
				rd_r <= sv_r;
			else if (pop)
				rd_r <= rd_r + 1'b1;
			if (save_i && !restore_i)
				sv_r <= pop ? rd_r + 1'b1 : rd_r;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_r[AW-1:0]] <= in_data_i;
	end
endmodule

// ---- uet_rx_status.sv ----
// receive status with second copy for setup after zero-length packet
module uet_rx_status (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       iso_i,
	input  wire logic       frame_bit0_i,
	input  wire logic       done_i,
	input  wire logic       zero_len_i,
	input  wire logic       setup_i,
	input  wire logic       pid1_i,
	input  wire logic       err_i,
	input  wire logic [6:0] fifo_count_i,
	input  wire logic       rd_i,
	output logic [7:0]      status_o
);
	logic [3:0] pri_r;
	logic [3:0] pri_nxt;
	logic [2:0] sec_r;
	logic [2:0] sec_nxt;
	logic       sec_v_r;
	logic       sec_v_nxt;
	logic       zlp_r;
	logic       zlp_nxt;
	logic [2:0] ev;
	logic [3:0] cnt;

	function automatic logic [3:0] sat15(input logic [6:0] c);
		sat15 = (c > 7'(uet_pkg::RECEIVE_BYTE_COUNT_MAX)) ? uet_pkg::RECEIVE_BYTE_COUNT_MAX : c[3:0];
	endfunction

	// setup, data pid or frame bit, last
	assign ev = {setup_i, iso_i ? frame_bit0_i : pid1_i, 1'b1}; // R19 R20 R21

	always_comb
	begin
		pri_nxt   = pri_r;
		sec_nxt   = sec_r;
		sec_v_nxt = sec_v_r;
		zlp_nxt   = zlp_r;
		if (rd_i)
		begin
			if (sec_v_r)
			begin
				pri_nxt   = {1'b0, sec_r}; // R17
				sec_v_nxt = 1'b0;
			end
			else
				pri_nxt = 4'h0; // R19 R20 R21
			zlp_nxt = 1'b0;
		end
		// event wins over the clear of the same cycle
		if (done_i)
		begin
			if (zlp_nxt && setup_i && !zero_len_i)
			begin
				sec_nxt   = ev; // R17
				sec_v_nxt = 1'b1;
			end
			else
			begin
				pri_nxt[2:0] = ev;
				zlp_nxt      = zero_len_i;
			end
		end
		if (err_i)
			pri_nxt[3] = 1'b1; // R22
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pri_r   <= uet_pkg::RXS_RESET[7:4];
			sec_r   <= 3'h0;
			sec_v_r <= 1'b0;
			zlp_r   <= 1'b0;
		end
		else
		begin
			pri_r   <= pri_nxt;
			sec_r   <= sec_nxt;
			sec_v_r <= sec_v_nxt;
			zlp_r   <= zlp_nxt;
		end
	end

	// zero-length copy reports no bytes while setup waits behind it
	assign cnt      = (zlp_r && sec_v_r) ? 4'h0 : sat15(fifo_count_i); // R18
	assign status_o = {pri_r, cnt};

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	rx_err_set_a: assert property (err_i |=> pri_r[3]) // R22
		else $error("receive error flag not set");
	rx_cnt_sat_a: assert property ( // R18
		(fifo_count_i > 7'd15 && !(zlp_r && sec_v_r)) |-> cnt == 4'hf)
		else $error("receive count not saturated");
	rx_two_copy_a: assert property ( // R17
		(rd_i && sec_v_r && !done_i) |=> pri_r[2:0] == $past(sec_r))
		else $error("second status copy not presented");
	rx_setup_cv: cover property (done_i && zlp_r && setup_i && !zero_len_i);
endmodule

// ---- uet_top.sv ----
// transmit endpoint control, data port and receive status registers
//
// Contract
// R01 - done set by packet, stall or iso frame
// R02 - status read clears done, ack, underrun
// R03 - non-iso ack flag follows host ACK
// R04 - iso ack only on matched sent frame
// R05 - empty FIFO unmarked: underrun, stuff error, EOP
// R06 - firmware sets enable, device clears after packet
// R07 - last bit marks packet; empty means zero-length
// R08 - last cleared after payload, CRC and EOP
// R09 - data pid bit picks DATA0/DATA1, untouched
// R10 - iso sends only on frame bit match
// R11 - iso always sends DATA0
// R12 - flush empties FIFO after transfer, self-clears
// R13 - last saves pointer, refill restores it
// R14 - warning at limit only while enabled
// R15 - frame lock override sends on next IN
// R16 - data port takes payload only
// R17 - two receive status copies for setup
// R18 - receive count saturates at fifteen
// R19 - receive last flag, cleared by read
// R20 - receive pid or frame bit, read clears
// R21 - setup flag, cleared by read
// R22 - receive error flag on media error
// R23 - iso endpoint never answers NAK
// R24 - free count saturates at thirty-one
module uet_top (
	input  wire logic       CORE_CLK_I,
	input  wire logic       RST_I,
	input  wire logic [5:0] ADDR_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	input  wire logic [7:0] WDATA_I,
	output logic [7:0]      RDATA_O,
	input  wire logic       EP_ISO_I,
	input  wire logic       EP_STALL_I,
	input  wire logic       FRAME_BIT0_I,
	input  wire logic       SOF_I,
	input  wire logic       IN_TOKEN_I,
	input  wire logic       TX_READY_I,
	input  wire logic       PKT_END_I,
	input  wire logic       HS_ACK_I,
	input  wire logic       HS_NONE_I,
	output logic            TX_START_O,
	output logic            TX_PID_O,
	output logic            TX_VALID_O,
	output logic [7:0]      TX_DATA_O,
	output logic            TX_PAYLOAD_END_O,
	output logic            FORCE_STUFF_O,
	output logic            STALL_O,
	output logic            NAK_O,
	output logic            TX_WARN_O,
	output logic            TX_SPACE_O,
	input  wire logic       RX_DONE_I,
	input  wire logic       RX_ZERO_LEN_I,
	input  wire logic       RX_SETUP_I,
	input  wire logic       RX_PID1_I,
	input  wire logic       RX_ERR_I,
	input  wire logic [6:0] RX_COUNT_I
);
	localparam int CW = $clog2(uet_pkg::FIFO_DEPTH) + 1;

	uet_pkg::uet_tx_state_t state_r;
	uet_pkg::uet_tx_state_t state_nxt;

	logic          tx_en_r;
	logic          last_r;
	logic          toggle_r;
	logic          flush_r;
	logic          refill_r;
	logic [1:0]    wlim_r;
	logic          ovr_r;
	logic          done_r;
	logic          ack_r;
	logic          urun_r;
	logic          match_r;
	logic          in_seen_r;
	logic          wr_txc;
	logic          wr_txd;
	logic          rd_txs;
	logic          rd_rxs;
	logic          f_ready;
	logic          f_valid;
	logic [7:0]    f_data;
	logic [CW-1:0] f_count;
	logic          f_pop;
	logic          f_flush;
	logic          f_save;
	logic          f_restore;
	logic          start;
	logic          done_set;
	logic          ack_set;
	logic          ack_clr;
	logic          en_clr;
	logic          last_clr;
	logic          rel;
	logic          urun_ev;
	logic          pay_end;
	logic          stall_ev;
	logic          nak_ev;
	logic          pend;
	logic          lock_ok;
	logic [4:0]    free;
	logic [4:0]    remain;
	logic [7:0]    rx_status;

	function automatic logic [4:0] free_sat(input logic [CW-1:0] used);
		int f;
		f = uet_pkg::FIFO_DEPTH - int'(used);
		free_sat = (f > int'(uet_pkg::FREE_MAX)) ? uet_pkg::FREE_MAX
			: 5'(f);
	endfunction

	function automatic logic wlim_hit(input logic [1:0] lim,
		input logic [4:0] rem);
		unique case (lim)
			uet_pkg::WL_OFF: wlim_hit = 1'b0;
			uet_pkg::WL_4:   wlim_hit = rem <= uet_pkg::TH_4;
			uet_pkg::WL_8:   wlim_hit = rem <= uet_pkg::TH_8;
			default:         wlim_hit = rem <= uet_pkg::TH_16;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register decode
	assign wr_txc = WR_I && ADDR_I == uet_pkg::TXC_ADDR;
	assign wr_txd = WR_I && ADDR_I == uet_pkg::TXD_ADDR;
	assign rd_txs = RD_I && ADDR_I == uet_pkg::TXS_ADDR;
	assign rd_rxs = RD_I && ADDR_I == uet_pkg::RXS_ADDR;
	assign free   = free_sat(f_count); // R24
	assign remain = 5'(f_count) + 5'(TX_VALID_O);

	////////////////////////////////////////////////////////////////////////
	// transmit buffer
	assign f_pop = state_r == uet_pkg::ST_SEND && (!TX_VALID_O || TX_READY_I);

	uet_fifo #(
		.WIDTH(uet_pkg::FIFO_WIDTH),
		.DEPTH(uet_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i      (CORE_CLK_I),
		.rst_i      (RST_I),
		.in_valid_i (wr_txd), // R16
		.in_data_i  (WDATA_I),
		.in_ready_o (f_ready),
		.out_valid_o(f_valid),
		.out_data_o (f_data),
		.out_ready_i(f_pop),
		.flush_i    (f_flush),
		.save_i     (f_save),
		.restore_i  (f_restore),
		.count_o    (f_count)
	);

	////////////////////////////////////////////////////////////////////////
	// transmit sequencing
	assign pend    = flush_r || refill_r;
	assign lock_ok = !EP_ISO_I || ovr_r || FRAME_BIT0_I == toggle_r; // R10 R15

	always_comb
	begin
		state_nxt = state_r;
		start     = 1'b0;
		done_set  = 1'b0;
		ack_set   = 1'b0;
		ack_clr   = 1'b0;
		en_clr    = 1'b0;
		last_clr  = 1'b0;
		rel       = 1'b0;
		urun_ev   = 1'b0;
		pay_end   = 1'b0;
		stall_ev  = 1'b0;
		nak_ev    = 1'b0;
		f_flush   = 1'b0;
		f_restore = 1'b0;
		unique case (state_r)
			uet_pkg::ST_IDLE:
			begin
				if (flush_r)
				begin
					f_flush  = 1'b1; // R12
					last_clr = 1'b1;
				end
				else if (refill_r)
					f_restore = 1'b1; // R13
				if (IN_TOKEN_I && EP_STALL_I)
				begin
					stall_ev = 1'b1;
					done_set = 1'b1; // R01
					en_clr   = 1'b1; // R06
				end
				else if (IN_TOKEN_I && tx_en_r && !pend && lock_ok)
				begin
					start     = 1'b1;
					state_nxt = uet_pkg::ST_SEND;
				end
				else if (IN_TOKEN_I && !EP_ISO_I)
					nak_ev = 1'b1; // R23
				else if (SOF_I && EP_ISO_I && tx_en_r && !ovr_r && match_r
					&& !in_seen_r && !pend)
				begin
					f_flush  = 1'b1; // R04 R10
					done_set = 1'b1; // R01
					ack_clr  = 1'b1; // R04
					last_clr = 1'b1;
				end
			end
			uet_pkg::ST_SEND:
			begin
				if (!f_valid && !TX_VALID_O && last_r)
				begin
					pay_end   = 1'b1; // R07
					state_nxt = uet_pkg::ST_EOP;
				end
				else if (!f_valid && !TX_VALID_O && TX_READY_I && !wr_txd)
				begin
					urun_ev   = 1'b1; // R05
					state_nxt = uet_pkg::ST_EOP;
				end
			end
			uet_pkg::ST_EOP:
			begin
				if (PKT_END_I)
				begin
					last_clr = 1'b1; // R08
					if (EP_ISO_I)
					begin
						done_set  = 1'b1; // R01
						ack_set   = 1'b1; // R04
						en_clr    = 1'b1; // R06
						rel       = 1'b1;
						state_nxt = uet_pkg::ST_IDLE;
					end
					else
						state_nxt = uet_pkg::ST_HS;
				end
			end
			uet_pkg::ST_HS:
			begin
				if (HS_ACK_I || HS_NONE_I)
				begin
					done_set  = 1'b1; // R01
					ack_set   = HS_ACK_I; // R03
					ack_clr   = !HS_ACK_I; // R03
					rel       = HS_ACK_I;
					en_clr    = 1'b1; // R06
					state_nxt = uet_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// save on a fresh last mark, and release acknowledged bytes
	assign f_save = (wr_txc && WDATA_I[uet_pkg::LAST_BIT] && !last_r)
		|| rel; // R13

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
			state_r <= uet_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// transmit command register
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			{ovr_r, wlim_r, refill_r, flush_r, toggle_r, last_r, tx_en_r}
				<= uet_pkg::TXC_RESET; // R15
		end
		else if (wr_txc)
		begin
			tx_en_r  <= WDATA_I[uet_pkg::TX_EN_BIT]; // R06
			last_r   <= WDATA_I[uet_pkg::LAST_BIT]; // R07
			toggle_r <= WDATA_I[uet_pkg::TOGGLE_BIT]; // R09
			flush_r  <= WDATA_I[uet_pkg::FLUSH_BIT] | flush_r;
			refill_r <= WDATA_I[uet_pkg::REFILL_BIT] | refill_r;
			wlim_r   <= WDATA_I[uet_pkg::WLIM_LSB +: 2];
			ovr_r    <= WDATA_I[uet_pkg::OVR_BIT];
		end
		else
		begin
			if (en_clr)
				tx_en_r <= 1'b0; // R06
			if (last_clr)
				last_r <= 1'b0; // R08
			if (f_flush && state_r == uet_pkg::ST_IDLE && flush_r)
				flush_r <= 1'b0; // R12
			if (f_restore)
				refill_r <= 1'b0; // R13
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit status, cleared on read; a set in the same cycle wins
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			done_r <= 1'b0;
			ack_r  <= 1'b0;
			urun_r <= 1'b0;
		end
		else
		begin
			done_r <= done_set || (done_r && !rd_txs); // R01 R02
			ack_r  <= ack_set || (ack_r && !rd_txs && !ack_clr); // R02 R03
			urun_r <= urun_ev || (urun_r && !rd_txs); // R02 R05
		end
	end

	// frame lock tracking for iso pre-queueing
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			match_r   <= 1'b0;
			in_seen_r <= 1'b0;
		end
		else
		begin
			match_r <= FRAME_BIT0_I == toggle_r; // R10
			if (SOF_I)
				in_seen_r <= 1'b0;
			else if (IN_TOKEN_I)
				in_seen_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link side outputs
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			TX_VALID_O <= 1'b0;
			TX_DATA_O  <= 8'h00;
		end
		else if (f_pop && f_valid)
		begin
			TX_VALID_O <= 1'b1;
			TX_DATA_O  <= f_data;
		end
		else if (TX_READY_I || state_r != uet_pkg::ST_SEND)
			TX_VALID_O <= 1'b0;
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			TX_START_O       <= 1'b0;
			TX_PID_O         <= 1'b0;
			TX_PAYLOAD_END_O <= 1'b0;
			FORCE_STUFF_O    <= 1'b0;
			STALL_O          <= 1'b0;
			NAK_O            <= 1'b0;
			TX_WARN_O        <= 1'b0;
			TX_SPACE_O       <= 1'b0;
		end
		else
		begin
			TX_START_O <= start;
			if (start)
				TX_PID_O <= EP_ISO_I ? 1'b0 : toggle_r; // R09 R11
			TX_PAYLOAD_END_O <= pay_end; // R07
			FORCE_STUFF_O    <= urun_ev; // R05
			STALL_O          <= stall_ev;
			NAK_O            <= nak_ev; // R23
			TX_WARN_O        <= tx_en_r && wlim_hit(wlim_r, remain); // R14
			TX_SPACE_O       <= f_ready;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive status and read data
	uet_rx_status u_rx (
		.clk_i       (CORE_CLK_I),
		.rst_i       (RST_I),
		.iso_i       (EP_ISO_I),
		.frame_bit0_i(FRAME_BIT0_I),
		.done_i      (RX_DONE_I),
		.zero_len_i  (RX_ZERO_LEN_I),
		.setup_i     (RX_SETUP_I),
		.pid1_i      (RX_PID1_I),
		.err_i       (RX_ERR_I),
		.fifo_count_i(RX_COUNT_I),
		.rd_i        (rd_rxs),
		.status_o    (rx_status)
	);

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
			RDATA_O <= 8'h00;
		else if (RD_I)
		begin
			if (ADDR_I == uet_pkg::TXS_ADDR)
				RDATA_O <= {urun_r, ack_r, done_r, free}; // R02 R24
			else if (ADDR_I == uet_pkg::TXC_ADDR)
				RDATA_O <= {ovr_r, wlim_r, refill_r, flush_r, toggle_r,
					last_r, tx_en_r};
			else if (ADDR_I == uet_pkg::RXS_ADDR)
				RDATA_O <= rx_status;
			else
				RDATA_O <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	ack_done_a: assert property ( // R01 R03
		(state_r == uet_pkg::ST_HS && HS_ACK_I) |=> done_r && ack_r)
		else $error("ack did not set done and ack status");
	read_clear_a: assert property ( // R02
		(rd_txs && !done_set) |=> !done_r)
		else $error("status read did not clear done");
	stall_clear_a: assert property ( // R06
		(state_r == uet_pkg::ST_IDLE && IN_TOKEN_I && EP_STALL_I && !wr_txc)
		|=> !tx_en_r && done_r && STALL_O)
		else $error("stall did not clear enable");
	underrun_a: assert property ( // R05
		urun_ev |=> urun_r && FORCE_STUFF_O ##1 !FORCE_STUFF_O)
		else $error("underrun not flagged");
	last_hold_a: assert property ( // R08
		(last_r && state_r == uet_pkg::ST_SEND && !wr_txc) |=> last_r)
		else $error("last cleared before end of packet");
	pid_sel_a: assert property ( // R09 R11
		start |=> TX_PID_O == ($past(EP_ISO_I) ? 1'b0 : $past(toggle_r)))
		else $error("wrong data pid");
	iso_lock_a: assert property ( // R10 R15
		(start && EP_ISO_I && !ovr_r) |-> FRAME_BIT0_I == toggle_r)
		else $error("iso sent outside its frame");
	flush_done_a: assert property ( // R12
		(state_r == uet_pkg::ST_IDLE && flush_r && !wr_txc)
		|=> !flush_r && f_count == '0)
		else $error("flush did not empty buffer");
	warn_gate_a: assert property ( // R14
		TX_WARN_O |-> $past(tx_en_r) && $past(wlim_r) != uet_pkg::WL_OFF)
		else $error("warning raised while disabled");
	no_iso_nak_a: assert property ( // R23
		NAK_O |-> !$past(EP_ISO_I))
		else $error("iso endpoint answered NAK");

	zlp_cv: cover property (start && !f_valid && last_r);
	urun_cv: cover property (urun_ev);
	refill_cv: cover property (f_restore);
	iso_drop_cv: cover property (f_flush && SOF_I);
endmodule

// ---- uet_host_model.sv ----
// host-side link model: tokens, byte acceptance, packet end, handshake
module uet_host_model (
	input  wire logic clk_i,
	input  wire logic tok_i,
	input  wire logic ack_i,
	input  wire logic slow_i,
	input  wire logic iso_i,
	input  wire logic pend_i,
	output logic      in_token_o,
	output logic      tx_ready_o,
	output logic      pkt_end_o,
	output logic      hs_ack_o,
	output logic      hs_none_o
);
	logic pe = 1'b0;
	logic hs = 1'b0;

	initial {in_token_o, tx_ready_o, pkt_end_o, hs_ack_o, hs_none_o} = '0;

	////////////////////////////////////////////////////////////////////////
	// crc and eop follow the payload end, handshake follows the packet
	always @(negedge clk_i)
	begin
		in_token_o <= tok_i;
		tx_ready_o <= slow_i ? 1'($urandom_range(0, 1)) : 1'b1;
		pkt_end_o  <= pe;
		pe         <= pend_i;
		hs         <= pe & ~iso_i;
		hs_ack_o   <= hs & ack_i;
		hs_none_o  <= hs & ~ack_i;
	end
endmodule

// ---- uet_top_tb_top.sv ----
// self-checking bench for the endpoint transmit/receive control block
module uet_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [5:0] addr = '0;
	logic [7:0] wd = '0;
	logic [6:0] rxc = '0;
	logic       wr = 0, rd = 0, iso = 0, stl_in = 0, fb0 = 0, sof = 0;
	logic       tok = 0, ack = 0, slow = 0, rxd = 0, rxz = 0, receive_status = 0;
	logic       rxp = 0, rxe = 0, rd_d = 0, p;
	logic [7:0] rdat, tdat, b;
	logic       start, pid, vld, pend, fst, stl, nak, warn, space;
	logic       itok, rdy, pkt, hack, hnone;
	logic [7:0] exp_q[$], msk_q[$], dat_q[$], sent[$];
	logic       pid_q[$];
	int         fails = 0, samples_checked = 0;
	int         n_st = 0, n_nak = 0, n_stl = 0, n_fs = 0, n_pk = 0, c0, c1;

	always #4 clk = ~clk;

	uet_top i_dut (
		.CORE_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WR_I(wr),
		.RD_I(rd), .WDATA_I(wd), .RDATA_O(rdat), .EP_ISO_I(iso),
		.EP_STALL_I(stl_in), .FRAME_BIT0_I(fb0), .SOF_I(sof),
		.IN_TOKEN_I(itok), .TX_READY_I(rdy), .PKT_END_I(pkt),
		.HS_ACK_I(hack), .HS_NONE_I(hnone), .TX_START_O(start),
		.TX_PID_O(pid), .TX_VALID_O(vld), .TX_DATA_O(tdat),
		.TX_PAYLOAD_END_O(pend), .FORCE_STUFF_O(fst), .STALL_O(stl),
		.NAK_O(nak), .TX_WARN_O(warn), .TX_SPACE_O(space),
		.RX_DONE_I(rxd), .RX_ZERO_LEN_I(rxz), .RX_SETUP_I(receive_status),
		.RX_PID1_I(rxp), .RX_ERR_I(rxe), .RX_COUNT_I(rxc)
	);

	uet_host_model i_host (
		.clk_i(clk), .tok_i(tok), .ack_i(ack), .slow_i(slow), .iso_i(iso),
		.pend_i(pend | fst), .in_token_o(itok), .tx_ready_o(rdy),
		.pkt_end_o(pkt), .hs_ack_o(hack), .hs_none_o(hnone)
	);

	task automatic chk(input logic [7:0] got, input logic [7:0] e);
		samples_checked++;
		if (got !== e)
		begin
			fails++;
			$display("Error t=%0t got %h expected %h", $time, got, e);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// result watcher: takes the oldest note whenever a result shows
	always @(posedge clk)
	begin
		rd_d  <= rd;
		n_st  <= n_st + (start === 1'b1);
		n_nak <= n_nak + (nak === 1'b1);
		n_stl <= n_stl + (stl === 1'b1);
		n_fs  <= n_fs + (fst === 1'b1);
		n_pk  <= n_pk + (pkt === 1'b1);
		if (start === 1'b1)
			chk({7'h0, pid}, {7'h0, pid_q.pop_front()});
		if (vld === 1'b1 && rdy === 1'b1)
			chk(tdat, dat_q.pop_front());
	end

	always @(negedge clk)
		if (rd_d)
		begin
			logic [7:0] m;
			m = msk_q.pop_front();
			chk(rdat & m, exp_q.pop_front() & m);
		end

	////////////////////////////////////////////////////////////////////////
	// register and link stimulus
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk);
		addr <= a;
		wd   <= d;
		wr   <= 1'b1;
		@(negedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [5:0] a, input logic [7:0] e,
		input logic [7:0] m);
		@(negedge clk);
		addr <= a;
		rd   <= 1'b1;
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(negedge clk);
		rd <= 1'b0;
	endtask

	task automatic tok_go;
		@(negedge clk);
		tok <= 1'b1;
		@(negedge clk);
		tok <= 1'b0;
		repeat (8) @(negedge clk);
	endtask

	task automatic wait_pkt(input int n0);
		for (int i = 0; i < 300 && n_pk == n0; i++)
			@(negedge clk);
		if (n_pk == n0)
		begin
			fails++;
			$display("Error t=%0t packet never ended", $time);
			tally_and_finish();
		end
		repeat (4) @(negedge clk);
	endtask

	task automatic send(input int nb, input logic [7:0] cmd, input logic a);
		int n0;
		logic [7:0] v;
		ack <= a;
		sent.delete();
		repeat (nb)
		begin
			v = 8'($urandom);
			sent.push_back(v);
			dat_q.push_back(v);
			wr_reg(uet_pkg::TXD_ADDR, v);
		end
		wr_reg(uet_pkg::TXC_ADDR, cmd);
		n0 = n_pk;
		tok_go();
		wait_pkt(n0);
	endtask

	task automatic rx_pkt(input logic z, input logic s, input logic q);
		@(negedge clk);
		{rxd, rxz, receive_status, rxp} <= {1'b1, z, s, q};
		@(negedge clk);
		rxd <= 1'b0;
	endtask

	initial
	begin
		void'($urandom(81));
		repeat (2) @(negedge clk);
		rst <= 1'b0;
		rd_reg(uet_pkg::TXC_ADDR, 8'h00, 8'hff);
		rd_reg(uet_pkg::TXS_ADDR, 8'h04, 8'hff);
		rd_reg(uet_pkg::RXS_ADDR, 8'h00, 8'hff);
		rd_reg(6'h00, 8'h00, 8'hff);
		pid_q.push_back(1'b1);
		send(2, 8'h07, 1'b1);
		rd_reg(uet_pkg::TXS_ADDR, 8'h64, 8'hff);
		rd_reg(uet_pkg::TXS_ADDR, 8'h04, 8'hff);
		rd_reg(uet_pkg::TXC_ADDR, 8'h04, 8'hff);
		pid_q.push_back(1'b1);
		send(0, 8'h07, 1'b1);
		rd_reg(uet_pkg::TXS_ADDR, 8'h64, 8'hff);
		slow <= 1'b1;
		pid_q.push_back(1'b0);
		send(2, 8'h03, 1'b0);
		rd_reg(uet_pkg::TXS_ADDR, 8'h24, 8'hff);
		foreach (sent[i]) dat_q.push_back(sent[i]);
		pid_q.push_back(1'b0);
		ack <= 1'b1;
		wr_reg(uet_pkg::TXC_ADDR, 8'h10);
		wr_reg(uet_pkg::TXC_ADDR, 8'h03);
		c0 = n_pk;
		tok_go();
		wait_pkt(c0);
		rd_reg(uet_pkg::TXS_ADDR, 8'h64, 8'hff);
		rd_reg(uet_pkg::TXC_ADDR, 8'h00, 8'h1a);
		slow <= 1'b0;
		c1 = n_fs;
		pid_q.push_back(1'b0);
		send(1, 8'h01, 1'b0);
		chk(8'(n_fs - c1), 8'h01);
		rd_reg(uet_pkg::TXS_ADDR, 8'h80, 8'h80);
		wr_reg(uet_pkg::TXC_ADDR, 8'h08);
		repeat (4) @(negedge clk);
		rd_reg(uet_pkg::TXC_ADDR, 8'h00, 8'h0b);
		iso <= 1'b1;
		fb0 <= 1'b1;
		pid_q.push_back(1'b0);
		send(1, 8'h07, 1'b1);
		rd_reg(uet_pkg::TXS_ADDR, 8'h64, 8'hff);
		b = 8'($urandom);
		wr_reg(uet_pkg::TXD_ADDR, b);
		fb0 <= 1'b0;
		wr_reg(uet_pkg::TXC_ADDR, 8'h07);
		c0 = n_st;
		c1 = n_nak;
		tok_go();
		chk(8'(n_st - c0), 8'h00);
		chk(8'(n_nak - c1), 8'h00);
		dat_q.push_back(b);
		pid_q.push_back(1'b0);
		wr_reg(uet_pkg::TXC_ADDR, 8'h87);
		c0 = n_pk;
		tok_go();
		wait_pkt(c0);
		rd_reg(uet_pkg::TXS_ADDR, 8'h64, 8'hff);
		// new frame, so the earlier token no longer counts
		{sof, fb0} <= 2'b11;
		@(negedge clk);
		sof <= 1'b0;
		wr_reg(uet_pkg::TXD_ADDR, 8'($urandom));
		wr_reg(uet_pkg::TXC_ADDR, 8'h07);
		@(negedge clk);
		{sof, fb0} <= 2'b10;
		@(negedge clk);
		sof <= 1'b0;
		repeat (4) @(negedge clk);
		rd_reg(uet_pkg::TXS_ADDR, 8'h24, 8'hff);
		iso <= 1'b0;
		// discard leaves enable set; drop it to provoke a NAK
		wr_reg(uet_pkg::TXC_ADDR, 8'h00);
		c0 = n_st;
		c1 = n_nak;
		tok_go();
		chk(8'(n_st - c0), 8'h00);
		chk(8'(n_nak - c1), 8'h01);
		stl_in <= 1'b1;
		wr_reg(uet_pkg::TXC_ADDR, 8'h01);
		c1 = n_stl;
		tok_go();
		chk(8'(n_stl - c1), 8'h01);
		rd_reg(uet_pkg::TXS_ADDR, 8'h20, 8'h20);
		rd_reg(uet_pkg::TXC_ADDR, 8'h00, 8'h01);
		stl_in <= 1'b0;
		repeat (5) wr_reg(uet_pkg::TXD_ADDR, 8'($urandom));
		chk({7'h0, space}, 8'h00);
		rd_reg(uet_pkg::TXS_ADDR, 8'h00, 8'h1f);
		for (int c = 0; c < 4; c++)
		begin
			wr_reg(uet_pkg::TXC_ADDR, 8'(c << 5) | 8'h01);
			repeat (3) @(negedge clk);
			chk({7'h0, warn}, {7'h0, c != 0});
		end
		wr_reg(uet_pkg::TXC_ADDR, 8'h20);
		repeat (3) @(negedge clk);
		chk({7'h0, warn}, 8'h00);
		wr_reg(uet_pkg::TXC_ADDR, 8'h08);
		repeat (4) @(negedge clk);
		rd_reg(uet_pkg::TXS_ADDR, 8'h04, 8'h1f);
		p = 1'($urandom);
		c0 = $urandom_range(0, 15);
		rx_pkt(1'b1, 1'b0, 1'b0);
		rxc <= 7'(c0);
		rx_pkt(1'b0, 1'b1, p);
		rd_reg(uet_pkg::RXS_ADDR, 8'h10, 8'hff);
		rd_reg(uet_pkg::RXS_ADDR, {2'b01, p, 1'b1, 4'(c0)}, 8'hff);
		rxc <= 7'($urandom_range(16, 127));
		rd_reg(uet_pkg::RXS_ADDR, 8'h0f, 8'hff);
		@(negedge clk);
		rxe <= 1'b1;
		@(negedge clk);
		rxe <= 1'b0;
		rd_reg(uet_pkg::RXS_ADDR, 8'h8f, 8'hff);
		{iso, fb0} <= {1'b1, ~p};
		rx_pkt(1'b0, 1'b0, 1'b0);
		rd_reg(uet_pkg::RXS_ADDR, {2'b00, ~p, 5'h1f}, 8'hff);
		rd_reg(uet_pkg::RXS_ADDR, 8'h0f, 8'hff);
		repeat (3) @(negedge clk);
		chk(8'(dat_q.size() + pid_q.size()), 8'h00);
		tally_and_finish();
	end
endmodule
